// ---- inc/hlcc_consts.svh ----
// Register map, reset values, field positions and timing figures of the loop control block.
`ifndef HLCC_CONSTS_SVH
`define HLCC_CONSTS_SVH
`define HLCC_ADDR_CTRL1   8'h1b
`define HLCC_ADDR_CTRL2   8'h1c
`define HLCC_RST_CTRL1    8'h93
`define HLCC_RST_CTRL2    8'hf5
`define HLCC_CTRL1_WMASK  8'hbf
`define HLCC_BIT_BOOST    7
`define HLCC_BIT_RSVD     6
`define HLCC_BIT_CM       5
`define HLCC_DT_MSB       4
`define HLCC_BIT_DIR      7
`define HLCC_BIT_BSTAB    6
`define HLCC_DT_W         21
`define HLCC_MID_LEVEL    8'h80
`define HLCC_ZERO_RD      8'h00
`define HLCC_CLK_MHZ      250
`define HLCC_LRA_STEP_US  100
`define HLCC_LRA_OFF_US   500
`define HLCC_ERM_STEP_US  200
`define HLCC_ERM_OFF_US   1000
`endif

// ---- inc/hlcc_pkg.sv ----
// Types shared by the loop control block.
`include "hlcc_consts.svh"
package hlcc_pkg;
  typedef enum logic [1:0] {
    HLCC_GAIN_NORMAL,
    HLCC_GAIN_BOOST,
    HLCC_GAIN_REDUCED
  } hlcc_gain_e;

  typedef struct packed {
    logic signed [8:0] amp;
    logic              brake;
  } hlcc_drive_s;

  typedef struct packed {
    logic [7:0]            ctrl1;
    logic [7:0]            ctrl2;
    logic [7:0]            rdata;
    logic [`HLCC_DT_W-1:0] dtime;
    logic                  loaded;
    hlcc_gain_e            gain;
    hlcc_drive_s           drive;
  } hlcc_state_s;

  typedef struct packed {
    logic [`HLCC_DT_W-1:0] cnt;
    logic                  tick;
  } hlcc_tmr_s;
endpackage : hlcc_pkg

// ---- rtl/hlcc_period_timer.sv ----
// Free running period timer that emits one pulse per programmed period.
`timescale 1ns/1ns
`include "hlcc_consts.svh"
module hlcc_period_timer (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  run_in,
  input  wire logic [`HLCC_DT_W-1:0] period_in,
  output logic                       tick_out
);
  hlcc_pkg::hlcc_tmr_s st_ff;
  hlcc_pkg::hlcc_tmr_s nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (!run_in) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt == '0) begin
      nxt_st.cnt = period_in;
    end else if (st_ff.cnt == `HLCC_DT_W'(1)) begin
      nxt_st.cnt  = period_in;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt - `HLCC_DT_W'(1);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_out = st_ff.tick;

  property p_tick_reload;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (run_in && st_ff.cnt == `HLCC_DT_W'(1)) |=> (tick_out && st_ff.cnt == $past(period_in));
  endproperty
  a_tick_reload: assert property (p_tick_reload) else $error("sample tick or reload wrong");
endmodule : hlcc_period_timer

// ---- rtl/hlcc_top.sv ----
// Loop control configuration registers and the playback logic they steer.
`timescale 1ns/1ns
`include "hlcc_consts.svh"
// Behaviour
// - Boost bit set raises loop gain while overdrive is active, unless the stabilizer reduction applies in the same cycle.
// - Common-mode bit drives the input trigger pin common-mode level; clear disables it.
// - In resonant mode the field only seeds drive time; device then adjusts it.
// - Resonant initial drive time is field times 0.1 ms plus 0.5 ms.
// - In rotating-mass mode field sets sampling period: field times 0.2 ms plus 1 ms.
// - Direction bit chooses unidirectional (0) or bidirectional (1) input interpretation.
// - Unidirectional output scales linearly with input; braking comes from feedback.
// - Unidirectional mode uses the full input range, one extra amplitude bit.
// - Bidirectional open loop: half input is zero, below brakes, above drives positive.
// - Stabilizer bit set reduces loop gain as braking nears completion.
module hlcc_top #(
  parameter int unsigned LRA_STEP_CYC = `HLCC_LRA_STEP_US * `HLCC_CLK_MHZ,
  parameter int unsigned LRA_OFF_CYC  = `HLCC_LRA_OFF_US * `HLCC_CLK_MHZ,
  parameter int unsigned ERM_STEP_CYC = `HLCC_ERM_STEP_US * `HLCC_CLK_MHZ,
  parameter int unsigned ERM_OFF_CYC  = `HLCC_ERM_OFF_US * `HLCC_CLK_MHZ
) (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  input  wire logic                  reg_wr_en_in,
  input  wire logic                  reg_rd_en_in,
  output logic [7:0]                 reg_rdata_out,
  input  wire logic                  lra_mode_in,
  input  wire logic                  open_loop_in,
  input  wire logic                  loop_start_in,
  input  wire logic                  overdrive_in,
  input  wire logic                  brake_near_done_in,
  input  wire logic                  brake_req_in,
  input  wire logic                  adj_valid_in,
  input  wire logic signed [15:0]    adj_delta_in,
  input  wire logic [7:0]            input_level_in,
  output logic                       overdrive_gain_boost_out,
  output logic                       common_mode_drive_en_out,
  output logic                       brake_gain_reduce_out,
  output logic                       input_direction_sel_out,
  output hlcc_pkg::hlcc_gain_e       loop_gain_sel_out,
  output logic [`HLCC_DT_W-1:0]      drive_time_cyc_out,
  output logic                       bemf_sample_tick_out,
  output hlcc_pkg::hlcc_drive_s      drive_out
);
  hlcc_pkg::hlcc_state_s   st_ff;
  hlcc_pkg::hlcc_state_s   nxt_st;
  logic [4:0]              dt_field;
  logic [`HLCC_DT_W-1:0]   lra_est;
  logic [`HLCC_DT_W-1:0]   erm_period;
  logic                    wr_ctrl1;
  logic                    wr_ctrl2;

  assign dt_field   = st_ff.ctrl1[`HLCC_DT_MSB:0];
  assign lra_est    = `HLCC_DT_W'(dt_field * LRA_STEP_CYC + LRA_OFF_CYC);
  assign erm_period = `HLCC_DT_W'(dt_field * ERM_STEP_CYC + ERM_OFF_CYC);
  assign wr_ctrl1   = reg_wr_en_in && (reg_addr_in == `HLCC_ADDR_CTRL1);
  assign wr_ctrl2   = reg_wr_en_in && (reg_addr_in == `HLCC_ADDR_CTRL2);

  always_comb begin
    nxt_st = st_ff;
    if (wr_ctrl1) begin
      nxt_st.ctrl1 = reg_wdata_in & `HLCC_CTRL1_WMASK;
    end else if (wr_ctrl2) begin
      nxt_st.ctrl2 = reg_wdata_in;
    end
    if (!reg_rd_en_in) begin
      nxt_st.rdata = st_ff.rdata;
    end else if (reg_addr_in == `HLCC_ADDR_CTRL1) begin
      nxt_st.rdata = st_ff.ctrl1 & `HLCC_CTRL1_WMASK;
    end else if (reg_addr_in == `HLCC_ADDR_CTRL2) begin
      nxt_st.rdata = st_ff.ctrl2;
    end else begin
      nxt_st.rdata = `HLCC_ZERO_RD;
    end
    // The field seeds the drive time; the resonance tracker trims it afterwards.
    if (!st_ff.loaded || loop_start_in || wr_ctrl1) begin
      nxt_st.dtime  = lra_est;
      nxt_st.loaded = !wr_ctrl1;
    end else if (adj_valid_in && lra_mode_in) begin
      nxt_st.dtime = st_ff.dtime + `HLCC_DT_W'(adj_delta_in);
    end
    if (st_ff.ctrl2[`HLCC_BIT_BSTAB] && brake_near_done_in) begin
      nxt_st.gain = hlcc_pkg::HLCC_GAIN_REDUCED;
    end else if (st_ff.ctrl1[`HLCC_BIT_BOOST] && overdrive_in) begin
      nxt_st.gain = hlcc_pkg::HLCC_GAIN_BOOST;
    end else begin
      nxt_st.gain = hlcc_pkg::HLCC_GAIN_NORMAL;
    end
    if (!st_ff.ctrl2[`HLCC_BIT_DIR]) begin
      nxt_st.drive.amp   = $signed({1'b0, input_level_in});
      nxt_st.drive.brake = brake_req_in;
    end else if (open_loop_in) begin
      nxt_st.drive.amp   = $signed({~input_level_in[7], input_level_in[6:0], 1'b0});
      nxt_st.drive.brake = input_level_in < `HLCC_MID_LEVEL;
    end else begin
      // Closed loop ignores the lower half; braking is left to the feedback.
      nxt_st.drive.amp   = input_level_in[7] ? $signed({1'b0, input_level_in[6:0], 1'b0}) : '0;
      nxt_st.drive.brake = brake_req_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_ff        <= '0;
      st_ff.ctrl1  <= `HLCC_RST_CTRL1;
      st_ff.ctrl2  <= `HLCC_RST_CTRL2;
      st_ff.gain   <= hlcc_pkg::HLCC_GAIN_NORMAL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  hlcc_period_timer u_bemf_timer (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .run_in    (!lra_mode_in),
    .period_in (erm_period),
    .tick_out  (bemf_sample_tick_out)
  );

  assign reg_rdata_out            = st_ff.rdata;
  assign overdrive_gain_boost_out = st_ff.ctrl1[`HLCC_BIT_BOOST];
  assign common_mode_drive_en_out = st_ff.ctrl1[`HLCC_BIT_CM];
  assign brake_gain_reduce_out    = st_ff.ctrl2[`HLCC_BIT_BSTAB];
  assign input_direction_sel_out  = st_ff.ctrl2[`HLCC_BIT_DIR];
  assign loop_gain_sel_out        = st_ff.gain;
  assign drive_time_cyc_out       = st_ff.dtime;
  assign drive_out                = st_ff.drive;

  property p_boost;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (overdrive_in && !brake_near_done_in && st_ff.ctrl1[`HLCC_BIT_BOOST])
        |=> loop_gain_sel_out == hlcc_pkg::HLCC_GAIN_BOOST;
  endproperty
  a_boost: assert property (p_boost) else $error("boost gain not applied in overdrive");

  property p_no_boost;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (!st_ff.ctrl1[`HLCC_BIT_BOOST] && !brake_near_done_in) |=> loop_gain_sel_out == hlcc_pkg::HLCC_GAIN_NORMAL;
  endproperty
  a_no_boost: assert property (p_no_boost) else $error("gain raised with boost cleared");

  property p_common_mode;
    @(posedge mclk_in) disable iff (!rst_n_in)
      wr_ctrl1 |=> (common_mode_drive_en_out == $past(reg_wdata_in[`HLCC_BIT_CM]))
        ##1 ($past(wr_ctrl1) || common_mode_drive_en_out == $past(reg_wdata_in[`HLCC_BIT_CM], 2));
  endproperty
  a_common_mode: assert property (p_common_mode) else $error("common-mode drive does not follow write");

  property p_seed;
    @(posedge mclk_in) disable iff (!rst_n_in)
      wr_ctrl1 |=> ##1 drive_time_cyc_out
        == `HLCC_DT_W'($past(reg_wdata_in[`HLCC_DT_MSB:0], 2) * LRA_STEP_CYC + LRA_OFF_CYC);
  endproperty
  a_seed: assert property (p_seed) else $error("drive time seed wrong");

  property p_adjust;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (st_ff.loaded && !loop_start_in && !wr_ctrl1 && adj_valid_in && lra_mode_in)
        |=> drive_time_cyc_out == $past(st_ff.dtime) + `HLCC_DT_W'($past(adj_delta_in));
  endproperty
  a_adjust: assert property (p_adjust) else $error("drive time not trimmed");

  property p_unidir;
    @(posedge mclk_in) disable iff (!rst_n_in)
      !input_direction_sel_out |=> (drive_out.amp == $signed({1'b0, $past(input_level_in)})
        && drive_out.brake == $past(brake_req_in));
  endproperty
  a_unidir: assert property (p_unidir) else $error("unidirectional scaling wrong");

  property p_bidir_open;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (input_direction_sel_out && open_loop_in && input_level_in == `HLCC_MID_LEVEL)
        |=> (drive_out.amp == '0 && !drive_out.brake);
  endproperty
  a_bidir_open: assert property (p_bidir_open) else $error("mid input not zero output");

  property p_stab;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (brake_near_done_in && brake_gain_reduce_out) |=> loop_gain_sel_out == hlcc_pkg::HLCC_GAIN_REDUCED;
  endproperty
  a_stab: assert property (p_stab) else $error("gain not reduced near brake end");

  property p_rsvd;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_rd_en_in && reg_addr_in == `HLCC_ADDR_CTRL1) |=> !reg_rdata_out[`HLCC_BIT_RSVD];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
endmodule : hlcc_top

// ---- testbench/hlcc_host_model.sv ----
// Host model that issues single-byte accesses on the register port.
`timescale 1ns/1ns
module hlcc_host_model (
  input  wire logic       mclk_in,
  input  wire logic [7:0] rdata_in,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out,
  output logic            wr_en_out,
  output logic            rd_en_out
);
  initial begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
  end

  // Released data shows the inverse so a stale value is never taken for a fresh one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    addr_out  = a;
    wdata_out = d;
    wr_en_out = 1'b1;
    @(negedge mclk_in);
    wr_en_out = 1'b0;
    wdata_out = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_in);
    addr_out  = a;
    rd_en_out = 1'b1;
    @(negedge mclk_in);
    rd_en_out = 1'b0;
    @(negedge mclk_in);
    d = rdata_in;
  endtask : rd
endmodule : hlcc_host_model

// ---- testbench/hlcc_top_tb.sv ----
// Self-checking bench for the loop control configuration block.
`timescale 1ns/1ns
`include "hlcc_consts.svh"
module hlcc_top_tb;
  logic                  mclk_in = 1'b0;
  logic                  rst_n_in = 1'b0;
  logic [7:0]            addr, wdata, rdata, lvl, d;
  logic                  wr_en, rd_en, boost, cm, red, dir, tick;
  logic                  lra = 1'b1, open_l = 1'b0, start = 1'b0, od = 1'b0;
  logic                  bnd = 1'b0, breq = 1'b0, adj_v = 1'b0;
  logic signed [15:0]    delta = 16'sh0000;
  hlcc_pkg::hlcc_gain_e  gain;
  logic [`HLCC_DT_W-1:0] dtime;
  hlcc_pkg::hlcc_drive_s drv;
  int                    fail_count = 0;
  int                    total_checks = 0;
  int                    n;

  initial lvl = 8'h00;
  always #2 mclk_in = ~mclk_in;

  hlcc_top #(.LRA_STEP_CYC(2), .LRA_OFF_CYC(5), .ERM_STEP_CYC(2), .ERM_OFF_CYC(10)) i_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_rdata_out(rdata), .lra_mode_in(lra),
    .open_loop_in(open_l), .loop_start_in(start), .overdrive_in(od), .brake_near_done_in(bnd),
    .brake_req_in(breq), .adj_valid_in(adj_v), .adj_delta_in(delta), .input_level_in(lvl),
    .overdrive_gain_boost_out(boost), .common_mode_drive_en_out(cm), .brake_gain_reduce_out(red),
    .input_direction_sel_out(dir), .loop_gain_sel_out(gain), .drive_time_cyc_out(dtime),
    .bemf_sample_tick_out(tick), .drive_out(drv));

  hlcc_host_model i_host (.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_en_out(wr_en), .rd_en_out(rd_en));

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_in);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic t_reset;
    chk(boost, 1);
    chk(cm, 0);
    chk(red, 1);
    chk(dir, 1);
    chk(dtime, 19 * 2 + 5);
    i_host.rd(8'h1b, d);
    chk(d, 8'h93);
    i_host.rd(8'h1c, d);
    chk(d, 8'hf5);
  endtask : t_reset

  task automatic t_ctrl1;
    i_host.wr(8'h1b, 8'hff);
    chk(cm, 1);
    i_host.rd(8'h1b, d);
    chk(d, 8'hbf);
    i_host.wr(8'h1b, 8'h0a);
    cyc(1);
    chk(cm, 0);
    chk(boost, 0);
    chk(dtime, 10 * 2 + 5);
    i_host.rd(8'h1a, d);
    chk(d, 8'h00);
  endtask : t_ctrl1

  task automatic t_adjust;
    delta = -16'sd5;
    adj_v = 1'b1;
    cyc(1);
    adj_v = 1'b0;
    chk(dtime, 20);
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    chk(dtime, 25);
    lra   = 1'b0;
    adj_v = 1'b1;
    cyc(1);
    adj_v = 1'b0;
    chk(dtime, 25);
  endtask : t_adjust

  task automatic t_tick;
    n = 0;
    while (tick !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    cyc(1);
    n = 1;
    while (tick !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk(n, 10 * 2 + 10);
  endtask : t_tick

  task automatic t_gain;
    i_host.wr(8'h1b, 8'h80);
    od = 1'b1;
    cyc(1);
    chk(gain, hlcc_pkg::HLCC_GAIN_BOOST);
    bnd = 1'b1;
    cyc(1);
    chk(gain, hlcc_pkg::HLCC_GAIN_REDUCED);
    i_host.wr(8'h1c, 8'h35);
    cyc(1);
    chk(gain, hlcc_pkg::HLCC_GAIN_BOOST);
    chk(dir, 0);
    chk(red, 0);
    od  = 1'b0;
    bnd = 1'b0;
    cyc(1);
    chk(gain, hlcc_pkg::HLCC_GAIN_NORMAL);
  endtask : t_gain

  task automatic t_drive;
    logic [7:0] lv [7] = '{8'h80, 8'hff, 8'h00, 8'h80, 8'hff, 8'hc0, 8'h40};
    logic [9:0] ex [7] = '{10'h101, 10'h1fe, 10'h201, 10'h000, 10'h1fc, 10'h101, 10'h001};
    for (int i = 0; i < 7; i++) begin
      if (i == 2) begin
        i_host.wr(8'h1c, 8'hf5);
      end
      open_l = (i >= 2 && i < 5);
      breq   = (i != 1);
      lvl    = lv[i];
      cyc(2);
      chk(drv, ex[i]);
    end
  endtask : t_drive

  // A reset in mid-run must bring every written setting back to its default.
  task automatic t_rerun;
    i_host.wr(8'h1b, 8'h20);
    i_host.wr(8'h1c, 8'h00);
    rst_n_in = 1'b0;
    cyc(2);
    rst_n_in = 1'b1;
    cyc(2);
    chk(boost, 1);
    chk(cm, 0);
    chk(red, 1);
    chk(dir, 1);
    chk(dtime, 19 * 2 + 5);
  endtask : t_rerun

  initial begin
    #8000;
    fail_count++;
    conclude();
  end

  initial begin
    cyc(3);
    rst_n_in = 1'b1;
    cyc(3);
    t_reset();
    t_ctrl1();
    t_adjust();
    t_tick();
    t_gain();
    t_drive();
    t_rerun();
    conclude();
  end
endmodule : hlcc_top_tb
